// ### hw/boot_rom_pkg.sv
package boot_rom_pkg;

  // ----------------------------------------------------------------
  // array geometry and decode
  // ----------------------------------------------------------------
  localparam int          ROM_BYTES      = 262144;
  localparam int          ROM_WORD_AW    = 16;
  localparam int          DATA_W         = 32;
  localparam logic [11:0] SPAN_TOP_ZERO  = 12'h000;
  localparam logic [31:0] FLASH_BASE     = 32'h02D00000;
  localparam logic [11:0] FLASH_OFS_PAD  = 12'h000;

  // ----------------------------------------------------------------
  // transfer size encoding
  // ----------------------------------------------------------------
  localparam logic [1:0]  SIZE_WORD      = 2'h0;
  localparam logic [1:0]  SIZE_BYTE      = 2'h1;
  localparam logic [1:0]  SIZE_HALF      = 2'h2;
  localparam logic [1:0]  SIZE_BAD       = 2'h3;

  // ----------------------------------------------------------------
  // reset timing; clock period in ns, divider in clocks, counts in low reference clock ticks
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS  = 5;
  localparam int          LOW_REF_DIV    = 6104;
  localparam logic [3:0]  RESET_HOLD     = 4'h8;
  localparam logic [3:0]  BOOT_SAMPLE    = 4'h4;
  localparam logic [3:0]  LAST_TICK      = 4'h1;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_RESET,
    PH_FIRST,
    PH_RUN
  } phase_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        supervisor;
    logic [1:0]  size;
    logic [31:0] addr;
  } bus_req_type;

  typedef struct packed {
    logic ack;
    logic err;
  } bus_rsp_type;

  typedef struct packed {
    logic        cs;
    logic [31:0] addr;
  } redirect_type;

  typedef struct packed {
    phase_type    phase;
    logic [15:0]  div_cnt;
    logic [3:0]   rst_cnt;
    logic         boot_n_q;
    bus_rsp_type  rsp;
    redirect_type redir;
  } state_type;

  localparam state_type STATE_RST = '{
    phase:    PH_RESET,
    div_cnt:  16'h0000,
    rst_cnt:  RESET_HOLD,
    boot_n_q: 1'b1,
    rsp:      '0,
    redir:    '0
  };

endpackage : boot_rom_pkg

// ### hw/boot_rom_slave.sv
// Operation
// - the array holds 256 Kbytes of code and data read by the processor.
// - byte, halfword and word reads are served over a 32-bit data path.
// - only the lanes of the requested size are valid; the whole word is returned.
// - any write to the memory space ends in a transfer error.
// - the array decodes from address zero to the top of its 256-Kbyte range.
// - addresses up to the echo limit alias onto the array by dropping upper bits.
// - accesses above the echo region within the decode span end in a transfer error.
// - with boot select asserted the array sits out the first fetch and the boot chip select serves it.
// - a protect bit restricts reads by the processor's supervisor state bit.
// - a read refused by protection ends in a transfer error.
// - boot select is taken three low reference ticks before reset output negation.
// - with boot select low the first fetch goes to the flash base address plus the low 20 bits of the fetch address.
// - the array is disabled only for the first access after reset and then answers normally.
// - with boot select high the first fetch is served by the array at the fetch address, like any later access.
// - the captured boot select is held and drives the disable and the chip select.
// - reset output stays asserted while any reset source is active.
`timescale 1ns/1ps
`default_nettype none

module boot_rom_slave
  import boot_rom_pkg::*;
#(
  parameter int DIV = LOW_REF_DIV
) (
  input  wire logic                   CLOCK,
  input  wire logic                   RST,
  input  wire logic                   RESET_REQ,
  input  wire logic                   BOOT_SELECT_N,
  input  wire logic                   ROM_PROTECT,
  input  wire bus_req_type            REQ,
  output var  bus_rsp_type            RSP,
  output var  logic [DATA_W-1:0]      RD_DATA,
  output var  redirect_type           REDIR,
  output var  logic                   RESET_OUT_N,
  input  wire logic                   LOAD_EN,
  input  wire logic [ROM_WORD_AW-1:0] LOAD_ADDR,
  input  wire logic [DATA_W-1:0]      LOAD_DATA
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic in_echo_span(input logic [31:0] a);
    in_echo_span = (a[31:20] == SPAN_TOP_ZERO);
  endfunction : in_echo_span

  function automatic logic refused(input bus_req_type r, input logic prot);
    refused = r.write
           || (r.size == SIZE_BAD)
           || !in_echo_span(r.addr)
           || (prot && !r.supervisor);
  endfunction : refused

  localparam logic [15:0] DIV_LAST = 16'(DIV - 1);

  state_type s_q;
  state_type s_d;
  logic      tick;
  logic      sample;
  logic      take;
  logic      rd_en;
  logic      redirect_now;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d          = s_q;
    s_d.rsp      = '0;
    s_d.redir.cs = 1'b0;
    tick         = (s_q.div_cnt == DIV_LAST);
    s_d.div_cnt  = tick ? 16'h0000 : s_q.div_cnt + 16'h0001;
    sample       = 1'b0;
    take         = 1'b0;
    rd_en        = 1'b0;
    redirect_now = 1'b0;
    case (s_q.phase)
      PH_RESET: begin
        // requests are ignored while reset output is asserted
        if (tick) begin
          if (s_q.rst_cnt == BOOT_SAMPLE) begin
            sample       = 1'b1;
            s_d.boot_n_q = BOOT_SELECT_N;
          end
          if (s_q.rst_cnt == LAST_TICK) begin
            s_d.phase = PH_FIRST;
          end
          s_d.rst_cnt = s_q.rst_cnt - LAST_TICK;
        end
      end
      PH_FIRST, PH_RUN: begin
        if (REQ.valid) begin
          take = 1'b1;
          if (s_q.phase == PH_FIRST) begin
            s_d.phase = PH_RUN;
          end
          if ((s_q.phase == PH_FIRST) && !s_q.boot_n_q) begin
            // external unit terminates this one, not the array
            redirect_now   = 1'b1;
            s_d.redir.cs   = 1'b1;
            s_d.redir.addr = FLASH_BASE + {FLASH_OFS_PAD, REQ.addr[19:0]};
          end else begin
            s_d.rsp.err = refused(REQ, ROM_PROTECT);
            s_d.rsp.ack = !refused(REQ, ROM_PROTECT);
            rd_en       = !refused(REQ, ROM_PROTECT);
          end
        end
      end
      default: begin
        s_d.phase = PH_RESET;
      end
    endcase
    if (RESET_REQ) begin
      s_d.phase   = PH_RESET;
      // divider left running, as the low reference clock is free;
      // so the hold after a request is seven to eight ticks long
      s_d.rst_cnt = RESET_HOLD;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // array; upper address bits dropped, so echoes cost nothing
  // ----------------------------------------------------------------
  rom_array #(
    .ADDR_W (ROM_WORD_AW),
    .WIDTH  (DATA_W)
  ) u_array (
    .clock   (CLOCK),
    .rd_en   (rd_en),
    .rd_addr (REQ.addr[ROM_WORD_AW+1:2]),
    .wr_en   (LOAD_EN),
    .wr_addr (LOAD_ADDR),
    .wr_data (LOAD_DATA),
    .rd_q    (RD_DATA)
  );

  assign RSP         = s_q.rsp;
  assign REDIR       = s_q.redir;
  assign RESET_OUT_N = (s_q.phase != PH_RESET);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  // answers come from registers, so every check on a taken access looks one cycle on
  // from the taking edge
  logic normal_take;
  assign normal_take = take && !redirect_now;

  chk_single_term: assert property (!(RSP.ack && RSP.err))
    else $error("ack and error together");

  chk_write_error: assert property (normal_take && REQ.write |=> RSP.err && !RSP.ack)
    else $error("write not ended in error");

  chk_range_error: assert property (normal_take && (REQ.addr[31:20] != 12'h000) |=> RSP.err)
    else $error("out of span access not ended in error");

  chk_protect_error: assert property (normal_take && ROM_PROTECT && !REQ.supervisor |=> RSP.err)
    else $error("protected read not refused");

  chk_echo_read: assert property (normal_take && !REQ.write && (REQ.size != SIZE_BAD)
      && (REQ.addr[31:20] == 12'h000) && (!ROM_PROTECT || REQ.supervisor)
      |=> RSP.ack && !RSP.err)
    else $error("echo read not acknowledged");

  chk_first_redirect: assert property ((s_q.phase == PH_FIRST) && !s_q.boot_n_q && REQ.valid
      |=> REDIR.cs && !RSP.ack && !RSP.err
          && (REDIR.addr == 32'h02D00000 + {12'h000, $past(REQ.addr[19:0])}))
    else $error("first fetch not redirected to flash");

  chk_first_internal: assert property ((s_q.phase == PH_FIRST) && s_q.boot_n_q && REQ.valid
      && !refused(REQ, ROM_PROTECT) |=> RSP.ack && !REDIR.cs)
    else $error("first fetch not served internally");

  chk_later_normal: assert property ($past(REDIR.cs) |-> !REDIR.cs
      && (s_q.phase == PH_RUN || s_q.phase == PH_RESET))
    else $error("array disabled beyond first access");

  chk_boot_capture: assert property (sample ##1 !$past(RESET_REQ)
      |-> (s_q.boot_n_q == $past(BOOT_SELECT_N)) && !RESET_OUT_N)
    else $error("boot select not captured");

  chk_reset_hold: assert property (RESET_REQ |=> !RESET_OUT_N [*2])
    else $error("reset output negated during reset request");

  chk_one_answer: assert property (take |=> RSP.ack || RSP.err || REDIR.cs)
    else $error("taken access left without termination");

  chk_no_answer: assert property (!take |=> !RSP.ack && !RSP.err && !REDIR.cs)
    else $error("termination without a taken access");

  chk_quiet_reset: assert property (!RESET_OUT_N |=> !RSP.ack && !RSP.err && !REDIR.cs)
    else $error("answer given while reset output asserted");

  chk_release_tick: assert property ($rose(RESET_OUT_N) |-> $past(tick) && ($past(s_q.rst_cnt) == LAST_TICK))
    else $error("reset output negated off the last hold tick");

  chk_run_enabled: assert property ((s_q.phase == PH_RUN) && REQ.valid && !refused(REQ, ROM_PROTECT)
      |=> RSP.ack && !RSP.err && !REDIR.cs)
    else $error("array refused a later access");

  cov_redirect:    cover property (REDIR.cs);
  cov_echo_ack:    cover property (normal_take && REQ.addr[19:18] != 2'h0 ##1 RSP.ack);
  cov_protect_err: cover property (normal_take && ROM_PROTECT && !REQ.supervisor ##1 RSP.err);
  cov_release:     cover property ($rose(RESET_OUT_N));
  cov_first_int:   cover property ((s_q.phase == PH_FIRST) && s_q.boot_n_q && REQ.valid ##1 RSP.ack);

endmodule : boot_rom_slave

`default_nettype wire

// ### hw/rom_array.sv
`timescale 1ns/1ps
`default_nettype none

module rom_array #(
  parameter int ADDR_W = 16,
  parameter int WIDTH  = 32
) (
  input  wire logic              clock,
  input  wire logic              rd_en,
  input  wire logic [ADDR_W-1:0] rd_addr,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]  wr_data,
  output var  logic [WIDTH-1:0]  rd_q
);

  // contents come in over the load port; no file is read
  logic [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_q <= mem[rd_addr];
    end
  end

endmodule : rom_array

`default_nettype wire

// ### test/core_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// processor core side of the internal bus
// ----------------------------------------------------------------
module core_model
  import boot_rom_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_out_n,
  input  wire logic        go,
  input  wire bus_req_type cmd,
  output var  bus_req_type req
);
  logic [31:0] last_q = 32'h00000000;

  always @(posedge clock) begin
    if (req.valid) begin
      last_q <= req.addr;
    end
  end

  // no request while reset output is asserted; idle address lines toggle
  always_comb begin
    req       = cmd;
    req.valid = go && rst_out_n;
    if (!req.valid) begin
      req.addr = ~last_q;
    end
  end
endmodule : core_model

`default_nettype wire

// ### test/onchip_boot_rom_slave_tb.sv
`timescale 1ns/1ps
`default_nettype none

module onchip_boot_rom_slave_tb;
  import boot_rom_pkg::*;
  localparam int DV = 4;
  logic         clock = 1'b0, rst = 1'b1, reset_req = 1'b0, boot_n = 1'b1, protect = 1'b0;
  logic         go = 1'b0, load_en = 1'b0, rst_out_n;
  logic [15:0]  load_addr = 16'h0000;
  logic [31:0]  load_data = 32'h00000000, rd_data;
  bus_req_type  cmd = '0, req;
  bus_rsp_type  rsp;
  redirect_type redir;
  int           failures = 0, n_checks = 0, cycles = 0;
  // access table: addr, {write, supervisor, size, protect, ack, err}, word index
  logic [31:0]  c_a [11] = '{32'h00000004, 32'h00000005, 32'h00000006, 32'h0003FFFC, 32'h00040004,
                            32'h000FFFFC, 32'h00000004, 32'h00100000, 32'h00000004, 32'h00000004, 32'h00000004};
  logic [6:0]   c_m [11] = '{7'h22, 7'h2A, 7'h32, 7'h22, 7'h22, 7'h22, 7'h61, 7'h21, 7'h39, 7'h05, 7'h26};
  logic [15:0]  c_w [11] = '{16'h0001, 16'h0001, 16'h0001, 16'hFFFF, 16'h0001, 16'hFFFF,
                            16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0001};

  always #2.5 clock = ~clock;

  core_model cpu (.clock(clock), .rst_out_n(rst_out_n), .go(go), .cmd(cmd), .req(req));

  boot_rom_slave #(.DIV(DV)) uut (
    .CLOCK(clock), .RST(rst), .RESET_REQ(reset_req), .BOOT_SELECT_N(boot_n), .ROM_PROTECT(protect),
    .REQ(req), .RSP(rsp), .RD_DATA(rd_data), .REDIR(redir), .RESET_OUT_N(rst_out_n),
    .LOAD_EN(load_en), .LOAD_ADDR(load_addr), .LOAD_DATA(load_data));

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] word_of(logic [15:0] i);
    return {16'hC0DE, i};
  endfunction : word_of

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // request held one cycle, answer looked at in the cycle after the taking edge
  task automatic access(logic wr, logic sup, logic [1:0] sz, logic [31:0] a);
    @(posedge clock);
    cmd <= '{valid: 1'b1, write: wr, supervisor: sup, size: sz, addr: a};
    go  <= 1'b1;
    @(posedge clock);
    go  <= 1'b0;
    #1;
  endtask : access

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_internal_boot();
    access(1'b0, 1'b1, SIZE_WORD, 32'h00000000);
    chk("first fetch rsp", 32'h2, {30'h0, rsp});
    chk("first fetch data", word_of(16'h0000), rd_data);
    chk("first fetch cs", 32'h0, {31'h0, redir.cs});
    $display("test internal boot done");
  endtask : test_internal_boot

  task automatic test_decode();
    for (int i = 0; i < 11; i++) begin
      @(posedge clock);
      protect <= c_m[i][2];
      access(c_m[i][6], c_m[i][5], c_m[i][4:3], c_a[i]);
      chk($sformatf("rsp case %0d", i), {30'h0, c_m[i][1:0]}, {30'h0, rsp});
      if (c_m[i][1]) begin
        chk($sformatf("data case %0d", i), word_of(c_w[i]), rd_data);
      end
    end
    @(posedge clock);
    protect <= 1'b0;
    $display("test decode done");
  endtask : test_decode

  // boot select low at the sample point, raised again before negation
  task automatic test_external_boot();
    int n;
    n = 0;
    @(posedge clock);
    boot_n    <= 1'b0;
    reset_req <= 1'b1;
    @(posedge clock);
    reset_req <= 1'b0;
    #1;
    while (rst_out_n !== 1'b1 && n < 200) begin
      @(posedge clock);
      n++;
      if (n == 6 * DV) begin
        boot_n <= 1'b1;
      end
      #1;
    end
    chk("hold in range", 32'h1, {31'h0, n >= 7 * DV + 1 && n <= 8 * DV});
    access(1'b0, 1'b1, SIZE_WORD, 32'h00000000);
    chk("redirect rsp", 32'h0, {30'h0, rsp});
    chk("redirect cs", 32'h1, {31'h0, redir.cs});
    chk("redirect addr", FLASH_BASE, redir.addr);
    access(1'b0, 1'b1, SIZE_WORD, 32'h00000000);
    chk("second fetch rsp", 32'h2, {30'h0, rsp});
    chk("second fetch data", word_of(16'h0000), rd_data);
    $display("test external boot done");
  endtask : test_external_boot

  // ----------------------------------------------------------------
  // sequence and hang guard
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      $display("run cut short at cycle limit");
      complete_run();
    end
  end

  initial begin
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      load_en   <= i < 3;
      load_addr <= (i == 2) ? 16'hFFFF : i[15:0];
      load_data <= word_of((i == 2) ? 16'hFFFF : i[15:0]);
      rst       <= (i < 4);
    end
    #1;
    for (int n = 0; n < 200 && rst_out_n !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    test_internal_boot();
    test_decode();
    test_external_boot();
    complete_run();
  end
endmodule : onchip_boot_rom_slave_tb

`default_nettype wire
